// [core/scs_defs.vh]
/*
  Constants of the conversion sequencer: clock rate, conversion and
  frame timings per speed mode, and serial clock half periods.
  Assumes a single 25 MHz system clock.
*/
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// System clock
`define SCS_CLK_NS              40

// Result width and buffer depth
`define SCS_RES_W               18
`define SCS_FIFO_DEPTH          8

// Speed mode encodings
`define SCS_SPEED_FAST          2'h0
`define SCS_SPEED_NORMAL        2'h1
`define SCS_SPEED_LOWPWR        2'h2

// Longest conversion time per speed mode, ns
`define SCS_T_CONV_FAST_NS      1000
`define SCS_T_CONV_NORMAL_NS    1250
`define SCS_T_CONV_LOWPWR_NS    1500

// Cycles reserved for input sync, result hand-off and serial margin
`define SCS_CONV_MARGIN         8
`define SCS_CONV_FAST_CYC       ((`SCS_T_CONV_FAST_NS / `SCS_CLK_NS) - `SCS_CONV_MARGIN)
`define SCS_CONV_NORMAL_CYC     ((`SCS_T_CONV_NORMAL_NS / `SCS_CLK_NS) - `SCS_CONV_MARGIN)
`define SCS_CONV_LOWPWR_CYC     ((`SCS_T_CONV_LOWPWR_NS / `SCS_CLK_NS) - `SCS_CONV_MARGIN)

// Result enters the buffer this many cycles before the sequencer leaves ST_CONV
`define SCS_PUSH_LEAD           2

// Frame delay after convert start in read-during-convert, ns
`define SCS_T_FRAME_FAST_NS     25
`define SCS_T_FRAME_NORMAL_NS   275
`define SCS_T_FRAME_LOWPWR_NS   525
`define SCS_FRAME_FAST_CYC      ((`SCS_T_FRAME_FAST_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_FRAME_NORMAL_CYC    ((`SCS_T_FRAME_NORMAL_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_FRAME_LOWPWR_CYC    ((`SCS_T_FRAME_LOWPWR_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

// Least serial clock high time per divider setting, ns
`define SCS_T_HIGH_DIV0_NS      12
`define SCS_T_HIGH_DIV1_NS      22
`define SCS_T_HIGH_DIV2_NS      50
`define SCS_T_HIGH_DIV3_NS      100
`define SCS_HALF_DIV0_CYC       ((`SCS_T_HIGH_DIV0_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_HALF_DIV1_CYC       ((`SCS_T_HIGH_DIV1_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_HALF_DIV2_CYC       ((`SCS_T_HIGH_DIV2_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_HALF_DIV3_CYC       ((`SCS_T_HIGH_DIV3_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

`endif

// [core/scs_sequencer.v]
/*
  Conversion sequencer of an 18-bit SAR converter: convert start
  handling, busy timing, result buffer to a parallel port and the
  serial master port. Assumes pins arrive asynchronously and the SAR
  core presents its code on i_conv_code in the system clock domain.
*/
`timescale 1ns/1ps
`include "scs_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Result buffer
module scs_fifo #(
  parameter W  = 18,
  parameter D  = 8,
  parameter AW = 3
) (
  // Clock and reset
  input  wire          i_sys_clk,
  input  wire          i_rst_b,
  // Fill side
  input  wire          i_wr_valid,
  output wire          o_wr_ready,
  input  wire [W-1:0]  i_wr_data,
  // Drain side
  output wire          o_rd_valid,
  input  wire          i_rd_ready,
  output wire [W-1:0]  o_rd_data
);
  reg  [W-1:0] mem [0:D-1];
  reg  [AW-1:0] wr_ptr_ff;
  reg  [AW-1:0] rd_ptr_ff;
  reg  [AW:0]   count_ff;
  wire          push;
  wire          pop;

  assign o_wr_ready = (count_ff != D[AW:0]);
  assign o_rd_valid = (count_ff != {(AW+1){1'b0}});
  assign o_rd_data  = mem[rd_ptr_ff];
  assign push       = i_wr_valid & o_wr_ready;
  assign pop        = o_rd_valid & i_rd_ready;

  always @(posedge i_sys_clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= i_wr_data;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule // scs_fifo

////////////////////////////////////////////////////////////////////////////////
module scs_sequencer (
  // Clock and reset
  input  wire                   i_sys_clk,
  input  wire                   i_rst_b,
  // Host pins
  input  wire                   i_convert_start_n,
  input  wire [1:0]             i_speed_mode,
  input  wire                   i_serial_master,
  input  wire                   i_read_after_convert,
  input  wire [1:0]             i_serial_clock_divider,
  // SAR core
  input  wire [`SCS_RES_W-1:0]  i_conv_code,
  // Status
  output wire                   o_busy,
  output wire                   o_acquiring,
  // Parallel result port
  output wire [`SCS_RES_W-1:0]  o_par_data,
  output wire                   o_par_valid,
  input  wire                   i_par_ready,
  // Serial master port
  output wire                   o_serial_clock,
  output wire                   o_frame_sync,
  output wire                   o_serial_result_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CONV = 2'h1;
  localparam ST_SER  = 2'h2;

  localparam NSYNC = 7;

  // Timing counts, cut to the widths of the counters that hold them
  localparam [31:0] CONV_FAST_W   = `SCS_CONV_FAST_CYC;
  localparam [31:0] CONV_NORMAL_W = `SCS_CONV_NORMAL_CYC;
  localparam [31:0] CONV_LOWPWR_W = `SCS_CONV_LOWPWR_CYC;
  localparam [31:0] FRAME_FAST_W  = `SCS_FRAME_FAST_CYC;
  localparam [31:0] FRAME_NORM_W  = `SCS_FRAME_NORMAL_CYC;
  localparam [31:0] FRAME_LOWP_W  = `SCS_FRAME_LOWPWR_CYC;
  localparam [31:0] HALF_DIV0_W   = `SCS_HALF_DIV0_CYC;
  localparam [31:0] HALF_DIV1_W   = `SCS_HALF_DIV1_CYC;
  localparam [31:0] HALF_DIV2_W   = `SCS_HALF_DIV2_CYC;
  localparam [31:0] HALF_DIV3_W   = `SCS_HALF_DIV3_CYC;
  localparam [31:0] PUSH_LEAD_W   = `SCS_PUSH_LEAD;

  // Pin synchronisers: stage 1 feeds stage 2 only
  reg  [NSYNC-1:0]        sync1_ff;
  reg  [NSYNC-1:0]        sync2_ff;
  reg                     cnv_d_ff;
  wire                    cnv_s;
  wire [1:0]              speed_s;
  wire                    master_s;
  wire                    rac_s;
  wire [1:0]              div_s;
  wire                    start_fall;

  reg  [1:0]              state_ff;
  reg  [1:0]              nxt_state;
  reg  [5:0]              elap_ff;
  reg  [5:0]              conv_len_ff;
  reg  [5:0]              frame_at_ff;
  reg  [1:0]              half_len_ff;
  reg                     master_ff;
  reg                     rac_ff;
  reg                     busy_ff;
  reg                     acq_ff;
  reg  [`SCS_RES_W-1:0]   result_ff;

  reg                     sh_active_ff;
  reg  [`SCS_RES_W-1:0]   sh_reg_ff;
  reg  [4:0]              sh_bit_ff;
  reg  [1:0]              sh_half_ff;
  reg                     sclk_ff;
  reg                     frame_ff;
  reg                     sdo_ff;
  reg                     sh_start;
  reg  [`SCS_RES_W-1:0]   sh_load;

  reg  [`SCS_RES_W-1:0]   par_data_ff;
  reg                     par_valid_ff;
  wire                    fifo_wr_ready;
  wire                    fifo_rd_valid;
  wire [`SCS_RES_W-1:0]   fifo_rd_data;
  wire                    fifo_rd_ready;
  wire                    push;

  //////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sync1_ff <= 7'h7F;
      sync2_ff <= 7'h7F;
      cnv_d_ff <= 1'b1;
    end else begin
      sync1_ff <= {i_convert_start_n, i_speed_mode, i_serial_master,
                   i_read_after_convert, i_serial_clock_divider};
      sync2_ff <= sync1_ff;
      cnv_d_ff <= cnv_s;
    end
  end

  assign cnv_s      = sync2_ff[6];
  assign speed_s    = sync2_ff[5:4];
  assign master_s   = sync2_ff[3];
  assign rac_s      = sync2_ff[2];
  assign div_s      = sync2_ff[1:0];
  assign start_fall = cnv_d_ff & ~cnv_s;

  //////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  assign push = (state_ff == ST_CONV) &&
                (elap_ff == conv_len_ff - 6'd1 - PUSH_LEAD_W[5:0]);

  always @* begin
    nxt_state = state_ff;
    sh_start  = 1'b0;
    sh_load   = result_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_fall && fifo_wr_ready) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (master_ff && !rac_ff && elap_ff == frame_at_ff - 6'd1) begin
          sh_start = 1'b1;
        end
        if (elap_ff == conv_len_ff - 6'd1) begin
          if (master_ff && rac_ff) begin
            nxt_state = ST_SER;
            sh_start  = 1'b1;
          end else begin
            nxt_state = ST_IDLE;
          end
        end
      end
      ST_SER: begin
        if (!sh_active_ff && !sh_start) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      state_ff    <= ST_IDLE;
      elap_ff     <= 6'h00;
      conv_len_ff <= 6'h00;
      frame_at_ff <= 6'h00;
      half_len_ff <= 2'h1;
      master_ff   <= 1'b0;
      rac_ff      <= 1'b0;
      busy_ff     <= 1'b0;
      acq_ff      <= 1'b0;
      result_ff   <= {`SCS_RES_W{1'b0}};
    end else begin
      state_ff <= nxt_state;
      busy_ff  <= (nxt_state != ST_IDLE);
      acq_ff   <= (nxt_state == ST_IDLE);
      if (state_ff == ST_CONV) begin
        elap_ff <= elap_ff + 6'd1;
      end else begin
        elap_ff <= 6'h00;
      end
      if (push) begin
        result_ff <= i_conv_code;
      end
      if (state_ff == ST_IDLE && nxt_state == ST_CONV) begin
        master_ff <= master_s;
        rac_ff    <= rac_s;
        case (speed_s)
          `SCS_SPEED_NORMAL: begin
            conv_len_ff <= CONV_NORMAL_W[5:0];
            frame_at_ff <= FRAME_NORM_W[5:0];
          end
          `SCS_SPEED_LOWPWR: begin
            conv_len_ff <= CONV_LOWPWR_W[5:0];
            frame_at_ff <= FRAME_LOWP_W[5:0];
          end
          default: begin
            conv_len_ff <= CONV_FAST_W[5:0];
            frame_at_ff <= FRAME_FAST_W[5:0];
          end
        endcase
        case (div_s)
          2'h1:    half_len_ff <= HALF_DIV1_W[1:0];
          2'h2:    half_len_ff <= HALF_DIV2_W[1:0];
          2'h3:    half_len_ff <= HALF_DIV3_W[1:0];
          default: half_len_ff <= HALF_DIV0_W[1:0];
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Serial master shifter: data changes on falling clock, host samples rising
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      sh_active_ff <= 1'b0;
      sh_reg_ff    <= {`SCS_RES_W{1'b0}};
      sh_bit_ff    <= 5'h00;
      sh_half_ff   <= 2'h0;
      sclk_ff      <= 1'b0;
      frame_ff     <= 1'b0;
      sdo_ff       <= 1'b0;
    end else if (sh_start) begin
      sh_active_ff <= 1'b1;
      sh_reg_ff    <= sh_load;
      sdo_ff       <= sh_load[`SCS_RES_W-1];
      sh_bit_ff    <= 5'h00;
      sh_half_ff   <= half_len_ff - 2'h1;
      sclk_ff      <= 1'b0;
      frame_ff     <= 1'b1;
    end else if (sh_active_ff) begin
      if (sh_half_ff == 2'h0) begin
        sh_half_ff <= half_len_ff - 2'h1;
        sclk_ff    <= ~sclk_ff;
        if (sclk_ff) begin
          if (sh_bit_ff == 5'd17) begin
            sh_active_ff <= 1'b0;
            frame_ff     <= 1'b0;
          end else begin
            sh_bit_ff <= sh_bit_ff + 5'd1;
            sh_reg_ff <= {sh_reg_ff[`SCS_RES_W-2:0], 1'b0};
            sdo_ff    <= sh_reg_ff[`SCS_RES_W-2];
          end
        end
      end else begin
        sh_half_ff <= sh_half_ff - 2'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Result buffer and parallel output stage
  scs_fifo #(
    .W  (`SCS_RES_W),
    .D  (`SCS_FIFO_DEPTH),
    .AW (3)
  ) u_fifo (
    .i_sys_clk  (i_sys_clk),
    .i_rst_b    (i_rst_b),
    .i_wr_valid (push),
    .o_wr_ready (fifo_wr_ready),
    .i_wr_data  (i_conv_code),
    .o_rd_valid (fifo_rd_valid),
    .i_rd_ready (fifo_rd_ready),
    .o_rd_data  (fifo_rd_data)
  );

  assign fifo_rd_ready = ~par_valid_ff | i_par_ready;

  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      par_data_ff  <= {`SCS_RES_W{1'b0}};
      par_valid_ff <= 1'b0;
    end else if (fifo_rd_ready) begin
      par_valid_ff <= fifo_rd_valid;
      if (fifo_rd_valid) begin
        par_data_ff <= fifo_rd_data;
      end
    end
  end

  assign o_busy              = busy_ff;
  assign o_acquiring         = acq_ff;
  assign o_par_data          = par_data_ff;
  assign o_par_valid         = par_valid_ff;
  assign o_serial_clock      = sclk_ff;
  assign o_frame_sync        = frame_ff;
  assign o_serial_result_out = sdo_ff;
endmodule // scs_sequencer

// [bench/scs_checker.sv]
/*
  Port timing checker of the conversion sequencer.
  Assumes the mode pins stay stable during each conversion.
*/
`timescale 1ns/1ps
module scs_checker (
  // Clock, reset and mode pins
  input wire       i_sys_clk,
  input wire       i_rst_b,
  input wire [1:0] i_speed_mode,
  input wire       i_serial_master,
  input wire       i_read_after_convert,
  input wire [1:0] i_serial_clock_divider,
  // Watched outputs
  input wire       o_busy,
  input wire       o_acquiring,
  input wire       o_par_valid,
  input wire       o_serial_clock,
  input wire       o_frame_sync
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wire       rac  = i_serial_master & i_read_after_convert;
  wire [1:0] md   = (i_speed_mode == 2'h3) ? 2'h0 : i_speed_mode;
  wire [1:0] dv   = i_serial_clock_divider;
  wire [3:0] pmin = (dv == 2'h3) ? 4'h6 : {2'h0, dv} + 4'h1;
  wire [3:0] pmax = 4'h1 << dv;
  reg  [8:0] busy_cnt_ff;
  reg  [3:0] per_cnt_ff;
  reg  [4:0] rise_cnt_ff;
  reg        sclk_q_ff;
  reg        seen_rise_ff;
  reg        seen_valid_ff;
  wire       rise = o_serial_clock & ~sclk_q_ff;
  function automatic int lim(input [1:0] m, input [1:0] d, input r);
    int t[3][4] = '{'{43, 62, 100, 175}, '{50, 68, 106, 181}, '{56, 75, 112, 187}};
    return r ? t[m][d] : 25 + 6 * m;
  endfunction
  always @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      busy_cnt_ff   <= 9'h0;
      per_cnt_ff    <= 4'h0;
      rise_cnt_ff   <= 5'h0;
      sclk_q_ff     <= 1'b0;
      seen_rise_ff  <= 1'b0;
      seen_valid_ff <= 1'b0;
    end else begin
      busy_cnt_ff   <= o_busy ? busy_cnt_ff + 9'h1 : 9'h0;
      per_cnt_ff    <= rise ? 4'h1 : per_cnt_ff + {3'h0, per_cnt_ff != 4'hF};
      rise_cnt_ff   <= o_frame_sync ? rise_cnt_ff + {4'h0, rise} : 5'h0;
      sclk_q_ff     <= o_serial_clock;
      seen_rise_ff  <= o_frame_sync & (seen_rise_ff | rise);
      seen_valid_ff <= o_busy & (seen_valid_ff | o_par_valid);
    end
  end
  sequence s_serial_begin;
    $rose(o_busy) && i_serial_master;
  endsequence
  a_busy_width_max: assert property (
    o_busy |-> busy_cnt_ff < lim(md, dv, rac))
    else $error("busy held too long");
  a_valid_before_fall: assert property (
    $fell(o_busy) && !i_serial_master |-> seen_valid_ff)
    else $error("busy fell without a valid result");
  a_acq_opposite: assert property ($past(i_rst_b) |-> o_acquiring != o_busy)
    else $error("acquiring not opposite of busy");
  a_frame_normal: assert property (
    s_serial_begin ##0 (!i_read_after_convert && md == 2'h1) |-> ##7 $rose(o_frame_sync))
    else $error("frame late in normal mode");
  a_frame_lowpwr: assert property (
    s_serial_begin ##0 (!i_read_after_convert && md == 2'h2) |-> ##14 $rose(o_frame_sync))
    else $error("frame late in low-power mode");
  a_frame_after_conv: assert property (
    s_serial_begin ##0 (rac && md == 2'h0) |-> ##[14:24] $rose(o_frame_sync))
    else $error("frame not at conversion end");
  a_busy_after_frame: assert property (rac && $fell(o_frame_sync) |=> $fell(o_busy))
    else $error("busy not dropped after frame");
  a_sclk_period: assert property (
    rise && seen_rise_ff && i_read_after_convert |-> per_cnt_ff >= pmin && per_cnt_ff <= pmax)
    else $error("serial clock period out of range");
  a_sclk_high: assert property (
    $rose(o_serial_clock) && i_read_after_convert && dv == 2'h3 |-> o_serial_clock[*3])
    else $error("serial clock high too short");
  a_frame_bits: assert property ($fell(o_frame_sync) |-> rise_cnt_ff == 5'h12)
    else $error("frame without eighteen clocks");
endmodule // scs_checker
bind scs_sequencer scs_checker scs_checker_inst (
  .i_sys_clk              (i_sys_clk),
  .i_rst_b                (i_rst_b),
  .i_speed_mode           (i_speed_mode),
  .i_serial_master        (i_serial_master),
  .i_read_after_convert   (i_read_after_convert),
  .i_serial_clock_divider (i_serial_clock_divider),
  .o_busy                 (o_busy),
  .o_acquiring            (o_acquiring),
  .o_par_valid            (o_par_valid),
  .o_serial_clock         (o_serial_clock),
  .o_frame_sync           (o_frame_sync)
);

// [bench/scs_host_model.sv]
/*
  Host reader model: queues parallel words, shifts in serial frames.
  Assumes the sequencer outputs change on the system clock.
*/
`timescale 1ns/1ps
module scs_host_model (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_b,
  // Slow reader request
  input  wire        i_stall,
  // Sequencer outputs
  input  wire        i_par_valid,
  input  wire [17:0] i_par_data,
  input  wire        i_sclk,
  input  wire        i_frame,
  input  wire        i_sdo,
  // Answers
  output wire        o_par_ready,
  output wire [17:0] o_ser_word
);
  logic [17:0] q[$];
  reg   [17:0] sh_ff = 18'h0;
  reg          sclk_q_ff = 1'b0;
  assign o_par_ready = i_rst_b & ~i_stall;
  assign o_ser_word  = sh_ff;
  always @(posedge i_sys_clk) begin
    sclk_q_ff <= i_sclk;
    if (o_par_ready && i_par_valid === 1'b1) q.push_back(i_par_data);
    // First bit taken is the most significant
    if (i_frame && i_sclk && !sclk_q_ff) sh_ff <= {sh_ff[16:0], i_sdo};
  end
endmodule // scs_host_model

// [bench/tb.sv]
/*
  Self-checking bench of the conversion sequencer.
  Assumes the checker is bound and the host model reads results.
*/
`timescale 1ns/1ps
module tb;
  reg        clk = 0, rst_b = 0, cnv_n = 1, sm = 0, rac = 0, stall = 0;
  reg  [1:0] mode = 0, div = 0;
  reg [17:0] code = 0;
  wire       busy, acq, pval, pready, sclk, frame, sdo;
  wire [17:0] pdata, sword;
  int        err_total = 0, cmp_count = 0, cyc = 0;
  always #20 clk = ~clk;
  scs_sequencer scs_sequencer_inst (.i_sys_clk(clk), .i_rst_b(rst_b),
    .i_convert_start_n(cnv_n), .i_speed_mode(mode), .i_serial_master(sm),
    .i_read_after_convert(rac), .i_serial_clock_divider(div), .i_conv_code(code),
    .o_busy(busy), .o_acquiring(acq), .o_par_data(pdata), .o_par_valid(pval),
    .i_par_ready(pready), .o_serial_clock(sclk), .o_frame_sync(frame),
    .o_serial_result_out(sdo));
  scs_host_model scs_host_model_inst (.i_sys_clk(clk), .i_rst_b(rst_b), .i_stall(stall),
    .i_par_valid(pval), .i_par_data(pdata), .i_sclk(sclk), .i_frame(frame),
    .i_sdo(sdo), .o_par_ready(pready), .o_ser_word(sword));
  task chk(string n, logic [17:0] e, logic [17:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", n, e, g);
      err_total++;
    end
  endtask
  task tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One start pulse; returns the busy width, 0 if refused
  task convert(output int w);
    int t;
    w = 0;
    t = 0;
    cnv_n = 0;
    tick(1);
    cnv_n = 1;
    while (busy !== 1'b1 && t < 8) begin tick(1); t++; end
    while (busy === 1'b1 && w < 400) begin tick(1); w++; t++; end
    while (t < 46) begin tick(1); t++; end
  endtask
  task t_par;
    int w;
    for (int m = 0; m < 3; m++) begin
      mode = 2'(m);
      code = 18'h2A5C3 + 18'(m);
      scs_host_model_inst.q.delete();
      convert(w);
      chk("busy width ok", 1, w > 0 && w <= 25 + 6 * m);
      chk("word count", 1, 18'(scs_host_model_inst.q.size()));
      chk("par word", code, scs_host_model_inst.q[0]);
    end
    $display("test parallel done");
  endtask
  task t_refuse;
    int w;
    mode = 0;
    code = 18'h1F00E;
    scs_host_model_inst.q.delete();
    cnv_n = 0;
    tick(1);
    cnv_n = 1;
    tick(8);
    cnv_n = 0;
    tick(1);
    cnv_n = 1;
    w = 0;
    while (busy === 1'b1 && w < 400) begin tick(1); w++; end
    tick(40);
    // Busy left from the first start only; a restart would stretch it
    chk("short busy", 1, w < 16);
    chk("acquiring", 1, acq);
    chk("word count", 1, 18'(scs_host_model_inst.q.size()));
    $display("test refuse done");
  endtask
  task t_fifo;
    int w, n;
    n = 0;
    mode = 0;
    stall = 1;
    scs_host_model_inst.q.delete();
    for (int i = 0; i < 10; i++) begin
      code = 18'h30000 + 18'(i);
      convert(w);
      n += (w > 0);
    end
    chk("accepted", 9, 18'(n));
    stall = 0;
    tick(20);
    chk("drained", 9, 18'(scs_host_model_inst.q.size()));
    for (int i = 0; i < 9; i++) begin
      chk("fifo word", 18'h30000 + 18'(i), scs_host_model_inst.q[i]);
    end
    $display("test buffer done");
  endtask
  task t_ser_after;
    int w;
    sm = 1;
    rac = 1;
    // Divider 00 is left out: its 40 ns period ceiling is below two system clocks
    for (int m = 0; m < 3; m++) for (int d = 1; d < 4; d++) begin
      mode = 2'(m);
      div = 2'(d);
      code = 18'h25A5A ^ 18'(m * 4 + d);
      convert(w);
      chk("serial word", code, sword);
    end
    $display("test serial after done");
  endtask
  task t_ser_during;
    int w;
    rac = 0;
    div = 0;
    for (int m = 0; m < 3; m++) begin
      mode = 2'(m);
      code = 18'h0C3A5 + 18'(m);
      convert(w);
      tick(20);
      code = 18'h3E1D2;
      convert(w);
      tick(20);
      chk("serial prev word", 18'h0C3A5 + 18'(m), sword);
    end
    $display("test serial during done");
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    tick(6);
    rst_b = 1;
    tick(3);
    chk("acquiring", 1, acq);
    t_par();
    t_refuse();
    t_fifo();
    t_ser_after();
    t_ser_during();
    test_done();
  end
endmodule // tb
